// File: bsfm_exec.sv
// Executor for branches, bit, shift, flag and X-indirect load operations behind AHB-Lite
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
module bsfm_exec #(
  parameter int unsigned DMEM_AW = 8
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic busy_o,
  output logic [7:0] status_reg_o
);
  import bsfm_pkg::*;

  logic [7:0] work_regs [32];
  logic [7:0] io_regs [64];
  logic [7:0] dmem [2**DMEM_AW];
  logic [7:0] status_reg_r;
  logic [15:0] pc_r;
  logic [15:0] xptr_r;
  bsfm_cmd_type cmd_r;
  bsfm_state_type state_r;
  bsfm_info_type info_r;
  logic [11:0] addr_r;
  logic wr_phase_r;
  logic rd_phase_r;
  logic rd_done_r;
  logic [31:0] hrdata_r;

  // Bus write applies only while the executor is idle
  logic bus_wr;
  logic bus_rd_cycle;
  logic addr_ok;
  assign addr_ok = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ)
    && (hsize_i == HSIZE_WORD);
  assign bus_wr = wr_phase_r && (state_r == ST_IDLE);
  assign bus_rd_cycle = rd_phase_r && !rd_done_r;

  // Region decode shared by read and write paths
  function automatic logic in_regs(input logic [11:0] a);
    return a[11:7] == REGS_TAG;
  endfunction
  function automatic logic in_io(input logic [11:0] a);
    return a[11:8] == IO_TAG;
  endfunction
  function automatic logic in_dmem(input logic [11:0] a);
    return a[11:10] == DMEM_TAG;
  endfunction
  function automatic logic [DMEM_AW-1:0] dm_idx(input logic [15:0] p);
    return p[DMEM_AW-1:0];
  endfunction

  // Address phase capture; reads take one wait state so hrdata comes from a flop
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_r <= 12'h000;
      wr_phase_r <= 1'b0;
      rd_phase_r <= 1'b0;
    end else begin
      if (hreadyout_o) begin
        addr_r <= haddr_i[11:0];
        wr_phase_r <= addr_ok && hwrite_i;
        rd_phase_r <= addr_ok && !hwrite_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_done_r <= 1'b0;
    end else begin
      rd_done_r <= bus_rd_cycle;
    end
  end

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (addr_r == ADDR_CMD) begin
      rd_val = cmd_r;
    end else if (addr_r == ADDR_STATUS) begin
      rd_val = {24'h00_0000, status_reg_r};
    end else if (addr_r == ADDR_PC) begin
      rd_val = {16'h0000, pc_r};
    end else if (addr_r == ADDR_XPTR) begin
      rd_val = {16'h0000, xptr_r};
    end else if (addr_r == ADDR_INFO) begin
      rd_val = {28'h000_0000, info_r};
    end else if (in_regs(addr_r)) begin
      rd_val = {24'h00_0000, work_regs[addr_r[6:2]]};
    end else if (in_io(addr_r)) begin
      rd_val = {24'h00_0000, io_regs[addr_r[7:2]]};
    end else if (in_dmem(addr_r) && (addr_r[9:2] <= 8'((2**DMEM_AW) - 1))) begin
      rd_val = {24'h00_0000, dmem[addr_r[DMEM_AW+1:2]]};
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hrdata_r <= 32'h0000_0000;
    end else if (bus_rd_cycle) begin
      hrdata_r <= rd_val;
    end
  end

  assign hrdata_o = hrdata_r;
  assign hreadyout_o = !bus_rd_cycle;
  assign hresp_o = 1'b0;                // Always OKAY
  assign busy_o = state_r != ST_IDLE;
  assign status_reg_o = status_reg_r;

  // Operation datapath, evaluated from the latched command
  logic [7:0] rd_old;
  logic [7:0] io_old;
  logic [15:0] x_dec;
  logic cond_true;
  logic is_branch;
  logic two_cycle;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_en;
  logic reg_we;
  logic [7:0] reg_wval;
  logic io_we;
  logic [7:0] io_wval;
  logic [7:0] status_reg_nxt;
  logic [15:0] pc_nxt;
  logic x_we;
  logic [15:0] x_nxt;
  logic [15:0] k_ext;

  assign rd_old = work_regs[cmd_r.rd];
  assign io_old = io_regs[cmd_r.io_addr];
  assign x_dec = xptr_r - XPTR_STEP;
  assign k_ext = {{9{cmd_r.k[6]}}, cmd_r.k};

  // Branch condition and cycle count
  always_comb begin
    is_branch = 1'b1;
    cond_true = 1'b0;
    unique case (bsfm_op_type'(cmd_r.op))
      OP_BR_OVF_SET: cond_true = status_reg_r[SB_V];   // [RULE1]
      OP_BR_OVF_CLR: cond_true = !status_reg_r[SB_V];  // [RULE1]
      OP_BR_IRQ_ON: cond_true = status_reg_r[SB_I];    // [RULE2]
      OP_BR_IRQ_OFF: cond_true = !status_reg_r[SB_I];  // [RULE2]
      default: is_branch = 1'b0;
    endcase
  end

  // Two-cycle ops: taken branches, I/O bit writes, X loads
  always_comb begin
    two_cycle = is_branch && cond_true;  // [RULE1] [RULE2]
    if (cmd_r.op == OP_IO_BIT_ONE || cmd_r.op == OP_IO_BIT_ZERO) begin
      two_cycle = 1'b1;  // [RULE3]
    end
    if (cmd_r.op == OP_LOAD_X_POSTINC || cmd_r.op == OP_LOAD_X_PREDEC) begin
      two_cycle = 1'b1;  // [RULE9] [RULE10]
    end
  end

  // Shifts and rotates, carry out picked per direction
  always_comb begin
    alu_en = 1'b1;
    alu_res = rd_old;
    alu_c = status_reg_r[SB_C];
    unique case (bsfm_op_type'(cmd_r.op))
      OP_SHL_LOGICAL: begin
        alu_res = {rd_old[6:0], 1'b0};  // [RULE4]
        alu_c = rd_old[7];
      end
      OP_ROL_CARRY: begin
        alu_res = {rd_old[6:0], status_reg_r[SB_C]};  // [RULE4]
        alu_c = rd_old[7];
      end
      OP_SHR_LOGICAL: begin
        alu_res = {1'b0, rd_old[7:1]};  // [RULE5]
        alu_c = rd_old[0];
      end
      OP_ROR_CARRY: begin
        alu_res = {status_reg_r[SB_C], rd_old[7:1]};  // [RULE5]
        alu_c = rd_old[0];
      end
      OP_SHR_ARITH: begin
        alu_res = {rd_old[7], rd_old[7:1]};  // [RULE13]
        alu_c = rd_old[0];
      end
      default: alu_en = 1'b0;
    endcase
  end

  // Result routing: register file, I/O space, status, pointer
  always_comb begin
    reg_we = 1'b0;
    reg_wval = rd_old;
    io_we = 1'b0;
    io_wval = io_old;
    status_reg_nxt = status_reg_r;
    x_we = 1'b0;
    x_nxt = xptr_r;
    if (alu_en) begin
      reg_we = 1'b1;
      reg_wval = alu_res;
      // Flags Z, C, N, V; V is N xor C after the shift
      status_reg_nxt[SB_Z] = alu_res == 8'h00;  // [RULE4] [RULE5] [RULE13]
      status_reg_nxt[SB_C] = alu_c;
      status_reg_nxt[SB_N] = alu_res[7];
      status_reg_nxt[SB_V] = alu_res[7] ^ alu_c;
    end
    unique case (bsfm_op_type'(cmd_r.op))
      OP_IO_BIT_ONE: begin
        io_we = 1'b1;
        io_wval[cmd_r.bit_sel] = 1'b1;  // [RULE3]
      end
      OP_IO_BIT_ZERO: begin
        io_we = 1'b1;
        io_wval[cmd_r.bit_sel] = 1'b0;  // [RULE3]
      end
      OP_STATUS_BIT_ONE: status_reg_nxt[cmd_r.bit_sel] = 1'b1;   // [RULE8]
      OP_STATUS_BIT_ZERO: status_reg_nxt[cmd_r.bit_sel] = 1'b0;  // [RULE8]
      OP_REG_BIT_TO_T: status_reg_nxt[SB_T] = work_regs[cmd_r.rr][cmd_r.bit_sel];  // [RULE6]
      OP_T_TO_REG_BIT: begin
        reg_we = 1'b1;
        reg_wval[cmd_r.bit_sel] = status_reg_r[SB_T];  // [RULE7]
      end
      OP_LOAD_X_POSTINC: begin
        reg_we = 1'b1;
        reg_wval = dmem[dm_idx(xptr_r)];  // [RULE9]
        x_we = 1'b1;
        x_nxt = xptr_r + XPTR_STEP;
      end
      OP_LOAD_X_PREDEC: begin
        reg_we = 1'b1;
        reg_wval = dmem[dm_idx(x_dec)];  // [RULE10]
        x_we = 1'b1;
        x_nxt = x_dec;
      end
      OP_CARRY_ONE: status_reg_nxt[SB_C] = 1'b1;  // [RULE8]
      OP_CARRY_ZERO: status_reg_nxt[SB_C] = 1'b0;
      OP_NEG_ONE: status_reg_nxt[SB_N] = 1'b1;
      OP_NEG_ZERO: status_reg_nxt[SB_N] = 1'b0;
      OP_ZERO_ONE: status_reg_nxt[SB_Z] = 1'b1;
      OP_ZERO_ZERO: status_reg_nxt[SB_Z] = 1'b0;
      OP_OVF_ONE: status_reg_nxt[SB_V] = 1'b1;    // [RULE11]
      OP_OVF_ZERO: status_reg_nxt[SB_V] = 1'b0;   // [RULE11]
      OP_SIGN_ONE: status_reg_nxt[SB_S] = 1'b1;   // [RULE12]
      OP_SIGN_ZERO: status_reg_nxt[SB_S] = 1'b0;  // [RULE12]
      OP_HALF_ONE: status_reg_nxt[SB_H] = 1'b1;   // [RULE8]
      OP_HALF_ZERO: status_reg_nxt[SB_H] = 1'b0;
      OP_XFER_ONE: status_reg_nxt[SB_T] = 1'b1;
      OP_XFER_ZERO: status_reg_nxt[SB_T] = 1'b0;
      OP_IRQ_ONE: status_reg_nxt[SB_I] = 1'b1;
      OP_IRQ_ZERO: status_reg_nxt[SB_I] = 1'b0;
      default: ;
    endcase
  end

  // Every op advances one word; a taken branch adds the signed offset too
  assign pc_nxt = (is_branch && cond_true) ? pc_r + k_ext + PC_STEP : pc_r + PC_STEP;

  logic commit;
  assign commit = (state_r == ST_EXEC1 && !two_cycle) || state_r == ST_EXEC2;

  // Sequencer: a write to the command register starts one operation
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (bus_wr && addr_r == ADDR_CMD) begin
            state_r <= ST_EXEC1;
          end
        end
        ST_EXEC1: state_r <= two_cycle ? ST_EXEC2 : ST_IDLE;
        ST_EXEC2: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Command latch and last-operation report
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_r <= '0;
      info_r <= '0;
    end else begin
      info_r.busy <= busy_o;
      if (bus_wr && addr_r == ADDR_CMD) begin
        cmd_r <= hwdata_i;
      end
      if (commit) begin
        info_r.taken <= is_branch && cond_true;
        info_r.cycles <= two_cycle ? 2'h2 : 2'h1;
      end
    end
  end

  // Status register: executor commit or software write while idle
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_reg_r <= STATUS_RESET;
    end else if (commit) begin
      status_reg_r <= status_reg_nxt;
    end else if (bus_wr && addr_r == ADDR_STATUS) begin
      status_reg_r <= hwdata_i[7:0];
    end
  end

  // Program counter
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pc_r <= PC_RESET;
    end else if (commit) begin
      pc_r <= pc_nxt;
    end else if (bus_wr && addr_r == ADDR_PC) begin
      pc_r <= hwdata_i[15:0];
    end
  end

  // X pointer
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      xptr_r <= XPTR_RESET;
    end else if (commit && x_we) begin
      xptr_r <= x_nxt;  // [RULE9] [RULE10]
    end else if (bus_wr && addr_r == ADDR_XPTR) begin
      xptr_r <= hwdata_i[15:0];
    end
  end

  // Working registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 32; i++) begin
        work_regs[i] <= 8'h00;
      end
    end else if (commit && reg_we) begin
      work_regs[cmd_r.rd] <= reg_wval;
    end else if (bus_wr && in_regs(addr_r)) begin
      work_regs[addr_r[6:2]] <= hwdata_i[7:0];
    end
  end

  // I/O registers; read-modify-write spans both cycles of the bit op
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < 64; i++) begin
        io_regs[i] <= 8'h00;
      end
    end else if (commit && io_we) begin
      io_regs[cmd_r.io_addr] <= io_wval;  // [RULE3]
    end else if (bus_wr && in_io(addr_r)) begin
      io_regs[addr_r[7:2]] <= hwdata_i[7:0];
    end
  end

  // Data memory has no reset: it models SRAM contents, filled by software
  always_ff @(posedge clk_i) begin
    if (bus_wr && in_dmem(addr_r) && (addr_r[9:2] <= 8'((2**DMEM_AW) - 1))) begin
      dmem[addr_r[DMEM_AW+1:2]] <= hwdata_i[7:0];
    end
  end

endmodule

// File: bsfm_pkg.sv
// Shared constants, opcodes and carrier types for the bit, shift, flag and move executor
// How it works
// RULE1 - Branch on overflow flag, 1 or 2 cycles
// RULE2 - Branch on global interrupt flag, 1/2 cycles
// RULE3 - Force one I/O bit, two cycles
// RULE4 - Left rotate and shift update Z,C,N,V
// RULE5 - Right rotate and shift update Z,C,N,V
// RULE6 - Copy register bit into transfer flag
// RULE7 - Copy transfer flag into register bit
// RULE8 - Set or clear any single status flag
// RULE9 - Load at X, then increment X
// RULE10 - Decrement X, then load at X
// RULE11 - Force overflow flag zero or one
// RULE12 - Force sign flag zero or one
// RULE13 - Arithmetic right shift keeps sign bit
package bsfm_pkg;

  // Byte offsets of the register map (low 12 address bits decoded)
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PC = 12'h008;
  localparam logic [11:0] ADDR_XPTR = 12'h00c;
  localparam logic [11:0] ADDR_INFO = 12'h010;
  localparam logic [4:0] REGS_TAG = 5'h01;   // 0x080..0x0fc, addr[11:7]
  localparam logic [3:0] IO_TAG = 4'h1;      // 0x100..0x1fc, addr[11:8]
  localparam logic [1:0] DMEM_TAG = 2'h1;    // 0x400..0x7fc, addr[11:10]

  // Status register bit positions
  localparam int unsigned SB_C = 0;
  localparam int unsigned SB_Z = 1;
  localparam int unsigned SB_N = 2;
  localparam int unsigned SB_V = 3;
  localparam int unsigned SB_S = 4;
  localparam int unsigned SB_H = 5;
  localparam int unsigned SB_T = 6;
  localparam int unsigned SB_I = 7;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] XPTR_RESET = 16'h0000;
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] XPTR_STEP = 16'h0001;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_BR_OVF_SET = 6'h01,
    OP_BR_OVF_CLR = 6'h02,
    OP_BR_IRQ_ON = 6'h03,
    OP_BR_IRQ_OFF = 6'h04,
    OP_IO_BIT_ONE = 6'h05,
    OP_IO_BIT_ZERO = 6'h06,
    OP_SHL_LOGICAL = 6'h07,
    OP_SHR_LOGICAL = 6'h08,
    OP_ROL_CARRY = 6'h09,
    OP_ROR_CARRY = 6'h0a,
    OP_SHR_ARITH = 6'h0b,
    OP_STATUS_BIT_ONE = 6'h0c,
    OP_STATUS_BIT_ZERO = 6'h0d,
    OP_REG_BIT_TO_T = 6'h0e,
    OP_T_TO_REG_BIT = 6'h0f,
    OP_LOAD_X_POSTINC = 6'h10,
    OP_LOAD_X_PREDEC = 6'h11,
    OP_CARRY_ONE = 6'h20,
    OP_CARRY_ZERO = 6'h21,
    OP_NEG_ONE = 6'h22,
    OP_NEG_ZERO = 6'h23,
    OP_ZERO_ONE = 6'h24,
    OP_ZERO_ZERO = 6'h25,
    OP_OVF_ONE = 6'h26,
    OP_OVF_ZERO = 6'h27,
    OP_SIGN_ONE = 6'h28,
    OP_SIGN_ZERO = 6'h29,
    OP_HALF_ONE = 6'h2a,
    OP_HALF_ZERO = 6'h2b,
    OP_XFER_ONE = 6'h2c,
    OP_XFER_ZERO = 6'h2d,
    OP_IRQ_ONE = 6'h2e,
    OP_IRQ_ZERO = 6'h2f
  } bsfm_op_type;

  // Command word written to ADDR_CMD, 32 bits
  typedef struct packed {
    logic [6:0] k;         // Signed branch offset
    logic [5:0] io_addr;   // I/O register index
    logic [4:0] rr;        // Source register
    logic [4:0] rd;        // Destination register
    logic [2:0] bit_sel;   // Bit index
    logic [5:0] op;        // bsfm_op_type code
  } bsfm_cmd_type;

  // Executor state visible at ADDR_INFO
  typedef struct packed {
    logic busy;
    logic taken;
    logic [1:0] cycles;
  } bsfm_info_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC1 = 2'b01,
    ST_EXEC2 = 2'b10
  } bsfm_state_type;

endpackage

// File: bsfm_chk_assertions.sv
// Checker on the executor's bus, busy and status ports, bound into the executor
`timescale 1ns/10ps
module bsfm_chk (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic busy_o,
  input wire logic [7:0] status_reg_o
);
  import bsfm_pkg::*;
  logic a_ok, ph_r, acc, tk;
  logic [8:0] cmd_r;
  logic [5:0] op;
  logic [5:0] op_in;
  logic [7:0] s, m;
  // Address phase taken by the slave, and a command accepted in its data phase
  assign a_ok = hsel_i && hready_i && htrans_i == HTRANS_NONSEQ && hsize_i == HSIZE_WORD;
  assign acc = ph_r && hready_i && !busy_o;
  assign op_in = hwdata_i[5:0];
  assign op = cmd_r[5:0];
  assign s = status_reg_o;
  // Branch outcome from the flags standing when the command is accepted
  assign tk = (op_in[1:0] == 2'h3 || op_in[2]) ? s[SB_I] ^ !op_in[0] : s[SB_V] ^ op_in[1];
  // Target flag; N and Z sit swapped against the order of the opcode pairs
  assign m = op[5] ? (op[3:1] == 3'h1 ? 8'h04 : op[3:1] == 3'h2 ? 8'h02 : 8'h01 << op[3:1])
    : 8'h01 << cmd_r[8:6];
  // Command latched, since its op is only visible during one data phase
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ph_r <= 1'b0;
      cmd_r <= 9'h000;
    end else begin
      if (hready_i) begin
        ph_r <= a_ok && hwrite_i && haddr_i[11:0] == ADDR_CMD;
      end
      if (acc) begin
        cmd_r <= hwdata_i[8:0];
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  read_wait_a: assert property (
    a_ok && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait wrong");
  write_nowait_a: assert property (
    a_ok && hwrite_i |=> hreadyout_o) else $error("write stalled");
  branch_taken_a: assert property (
    acc && op_in inside {[6'h01:6'h04]} && tk |=> busy_o[*2] ##1 !busy_o)
    else $error("taken branch not two cycles");
  branch_skip_a: assert property (
    acc && op_in inside {[6'h01:6'h04]} && !tk |=> busy_o ##1 !busy_o)
    else $error("untaken branch not one cycle");
  two_cycle_a: assert property (
    acc && op_in inside {6'h05, 6'h06, 6'h10, 6'h11} |=> busy_o ##1 busy_o ##1 !busy_o)
    else $error("op not two cycles");
  one_cycle_a: assert property (
    acc && op_in inside {[6'h07:6'h0f], [6'h20:6'h2f]} |=> busy_o ##1 !busy_o)
    else $error("op not one cycle");
  shift_flags_a: assert property (
    $fell(busy_o) && op inside {[6'h07:6'h0b]} |->
    s[SB_V] == (s[SB_N] ^ s[SB_C]) && s[7:4] == $past(s[7:4])) else $error("shift flags");
  flag_only_a: assert property (
    $fell(busy_o) && (op[5] || op[5:1] == 5'h06) |->
    (s & m) == (op[0] ? 8'h00 : m) && ((s ^ $past(s)) & ~m) == 8'h00) else $error("flag op");
endmodule

bind bsfm_exec bsfm_chk u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
  .hwdata_i(hwdata_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o), .busy_o(busy_o),
  .status_reg_o(status_reg_o));

// File: bsfm_ahb_master.sv
// Bus master model of the core side that feeds the executor
`timescale 1ns/10ps
module bsfm_ahb_master (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  import bsfm_pkg::*;
  logic hung;
  // Idle bus at time zero
  initial begin
    hung = 1'b0;
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o = 3'h0;
    hwdata_o = 32'h0;
  end
  // Bounded wait for hready, so a stuck slave cannot hang the run
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!hready_i && n < 64);
    hung = hung | !hready_i;
  endtask
  // One single word; released lines show the inverse rather than a stale value
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= HTRANS_NONSEQ;
    hwrite_o <= wr;
    hsize_o <= HSIZE_WORD;
    wait_rdy();
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    haddr_o <= ~a;
    hwdata_o <= wr ? d : ~d;
    wait_rdy();
    q = hrdata_i;
    hwdata_o <= ~d;
  endtask
endmodule

// File: tb.sv
// Self-checking bench for the bit, shift, flag and move executor
`timescale 1ns/10ps
module tb;
  import bsfm_pkg::*;
  logic clk, rst_n, hsel, hwrite, hrdy, hresp, busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0] st, status_reg, v, r;
  logic [15:0] pc;
  int err_total, checks_done;

  bsfm_exec #(.DMEM_AW(4)) DUT (.clk_i(clk), .reset_n_i(rst_n), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
    .hresp_o(hresp), .busy_o(busy), .status_reg_o(st));
  bsfm_ahb_master M (.clk_i(clk), .hready_i(hrdy), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
    .hwdata_o(hwdata));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Every access goes through the master model; a stuck slave ends the run
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    M.xfer(wr, a, d, q);
    if (M.hung) begin
      err_total++;
      finish_test();
    end
  endtask

  // One command, rd doubling as source register, then a bounded wait for idle
  task automatic exec(input logic [5:0] op, input logic [2:0] b, input logic [4:0] rd,
                      input logic [5:0] io, input logic [6:0] k);
    int n;
    bus(1'b1, 32'h0, {k, io, rd, rd, b, op});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy && n < 8);
    if (busy) begin
      err_total++;
      finish_test();
    end
  endtask

  // Dedicated flag opcodes, then the indexed form over all eight bits;
  // odd flags end up set so the branch tests see V and I at both levels
  task automatic t_flags();
    for (int o = 8'h20; o < 8'h30; o++) begin
      exec(o[5:0], 3'h0, 5'h00, 6'h00, 7'h00);
      status_reg[o[3:1] == 3'h1 ? 2 : o[3:1] == 3'h2 ? 1 : o[3:1]] = !o[0];
      chk("status", {8'h00, st}, {8'h00, status_reg});
    end
    for (int b = 0; b < 16; b++) begin
      exec((b < 8 || b[0]) ? 6'h0c : 6'h0d, b[2:0], 5'h00, 6'h00, 7'h00);
      status_reg[b[2:0]] = b < 8 || b[0];
      chk("status", {8'h00, st}, {8'h00, status_reg});
    end
  endtask

  // All four branches with both flag levels and a backward offset of three
  task automatic t_branch();
    logic t;
    for (int s = 0; s < 2; s++) begin
      for (int o = 1; o < 5; o++) begin
        bus(1'b0, {20'h0, ADDR_PC}, 32'h0);
        pc = q[15:0];
        t = o < 3 ? status_reg[SB_V] ^ (o == 2) : status_reg[SB_I] ^ (o == 4);
        exec(o[5:0], 3'h0, 5'h00, 6'h00, 7'h7d);
        bus(1'b0, {20'h0, ADDR_PC}, 32'h0);
        chk("pc", q[15:0], pc + (t ? 16'hfffe : 16'h0001));
        chk("status", {8'h00, st}, {8'h00, status_reg});
      end
      exec(6'h0d, 3'h3, 5'h00, 6'h00, 7'h00);
      exec(6'h0d, 3'h7, 5'h00, 6'h00, 7'h00);
      status_reg = status_reg & 8'h77;
    end
  endtask

  // Single I/O bits set at both ends and cleared, neighbours kept
  task automatic t_io();
    bus(1'b1, 32'h114, 32'h5a);
    exec(6'h05, 3'h0, 5'h00, 6'h05, 7'h00);
    exec(6'h05, 3'h7, 5'h00, 6'h05, 7'h00);
    exec(6'h06, 3'h1, 5'h00, 6'h05, 7'h00);
    bus(1'b0, 32'h114, 32'h0);
    chk("io", q[15:0], 16'h00d9);
    chk("status", {8'h00, st}, {8'h00, status_reg});
  endtask

  // Every shift and rotate on values that reach zero, sign and carry edges
  task automatic t_shift();
    logic [7:0] vals [4] = '{8'h81, 8'h01, 8'h80, 8'h7e};
    logic c;
    for (int o = 7; o < 12; o++) begin
      foreach (vals[i]) begin
        v = vals[i];
        bus(1'b1, 32'h08c, {24'h0, v});
        exec(o[5:0], 3'h0, 5'h03, 6'h00, 7'h00);
        case (o)
          7: {c, r} = {v, 1'b0};
          8: {r, c} = {1'b0, v};
          9: {c, r} = {v, status_reg[SB_C]};
          10: {r, c} = {status_reg[SB_C], v};
          default: {r, c} = {v[7], v};
        endcase
        status_reg[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
        bus(1'b0, 32'h08c, 32'h0);
        chk("shift", q[15:0], {8'h00, r});
        chk("status", {8'h00, st}, {8'h00, status_reg});
      end
    end
  endtask

  // Register bit to transfer flag and back, both flag levels
  task automatic t_bit();
    bus(1'b1, 32'h090, 32'h10);
    bus(1'b1, 32'h098, 32'h01);
    exec(6'h0e, 3'h4, 5'h04, 6'h00, 7'h00);
    status_reg[SB_T] = 1'b1;
    chk("status", {8'h00, st}, {8'h00, status_reg});
    exec(6'h0f, 3'h7, 5'h06, 6'h00, 7'h00);
    exec(6'h0e, 3'h3, 5'h04, 6'h00, 7'h00);
    status_reg[SB_T] = 1'b0;
    exec(6'h0f, 3'h0, 5'h06, 6'h00, 7'h00);
    chk("status", {8'h00, st}, {8'h00, status_reg});
    bus(1'b0, 32'h098, 32'h0);
    chk("reg bit", q[15:0], 16'h0080);
  endtask

  // Post-increment then pre-decrement through the pointer, distinct data at X and X+1
  task automatic t_xload();
    bus(1'b1, 32'h414, 32'h3c);
    bus(1'b1, 32'h418, 32'hc3);
    bus(1'b1, {20'h0, ADDR_XPTR}, 32'h5);
    exec(6'h10, 3'h0, 5'h07, 6'h00, 7'h00);
    bus(1'b0, 32'h09c, 32'h0);
    chk("postinc data", q[15:0], 16'h003c);
    bus(1'b0, {20'h0, ADDR_XPTR}, 32'h0);
    chk("postinc x", q[15:0], 16'h0006);
    exec(6'h11, 3'h0, 5'h08, 6'h00, 7'h00);
    bus(1'b0, 32'h0a0, 32'h0);
    chk("predec data", q[15:0], 16'h003c);
    bus(1'b0, {20'h0, ADDR_XPTR}, 32'h0);
    chk("predec x", q[15:0], 16'h0005);
    chk("status", {8'h00, st}, {8'h00, status_reg});
  endtask

  initial begin
    err_total = 0;
    checks_done = 0;
    status_reg = STATUS_RESET;
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk("resp", {15'h0, hresp}, 16'h0000);
    t_flags();
    t_branch();
    t_io();
    t_shift();
    t_bit();
    t_xload();
    finish_test();
  end

  // Run limit of 50000 cycles
  initial begin
    #2000000;
    err_total++;
    finish_test();
  end
endmodule
